// file: hdl/adcc_pkg.sv
// Constants and types shared by the converter control block
package adcc_pkg;

   // Register byte addresses on the special-function port
   localparam logic [7:0] ADDR_MODE = 8'h9A;
   localparam logic [7:0] ADDR_RES_HIGH = 8'h9B;
   localparam logic [7:0] ADDR_RES_LOW = 8'h9C;
   localparam logic [7:0] ADDR_TRIG_EN = 8'h9D;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h9E;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h9F;

   // Values after reset
   localparam logic [7:0] MODE_RESET = 8'h8F;
   localparam logic [7:0] MODE2_RESET = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [11:0] RESULT_RESET = 12'h000;

   // Field positions in the mode register
   localparam int MODE_CONVERTER_STANDBY = 7;
   localparam int MODE_START = 6;
   localparam int MODE_REF = 5;
   localparam int MODE_DONE = 4;

   // Field positions in the second mode register
   localparam int MODE2_EXTRG = 7;
   localparam int MODE2_TSEL = 4;
   localparam int MODE2_ALTCLK = 3;
   localparam int MODE2_ALIGN = 2;

   // Field positions in the trigger enable and interrupt registers
   localparam int TRIG_EN_COMP = 0;
   localparam int TRIG_EN_PWM = 1;
   localparam int IRQ_DONE = 0;

   // Channel code of the internal core supply
   localparam logic [3:0] CHAN_CORE_SUPPLY = 4'hF;

   // Converter clock divider: terminal count per select code
   localparam logic [1:0] CONVERTER_CLOCK_DIVIDE_DIV2 = 2'h0;
   localparam logic [1:0] CONVERTER_CLOCK_DIVIDE_DIV4 = 2'h1;
   localparam logic [1:0] CONVERTER_CLOCK_DIVIDE_DIV8 = 2'h2;
   localparam logic [4:0] DIV2_LAST = 5'h01;
   localparam logic [4:0] DIV4_LAST = 5'h03;
   localparam logic [4:0] DIV8_LAST = 5'h07;
   localparam logic [4:0] DIV32_LAST = 5'h1F;
   localparam logic [4:0] DIV_RESET = 5'h00;

   // Converter clock cycles per conversion and result width
   localparam int CONV_TICKS = 60;
   localparam int RESULT_BITS = 12;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b11
   } adcc_state_type;

endpackage

// file: hdl/adcc_conversion_control.sv
// Successive-approximation converter control with register port
//
// Summary of operation
// RL1 - Convert selected input to a 12-bit result by successive approximation.
// RL2 - Four-bit channel field in the mode register drives the multiplexer.
// RL3 - Writing start bit 1 begins a conversion, writing 0 stops it.
// RL4 - On completion load result registers, set done flag, raise interrupt.
// RL5 - Done flag reads 0 during conversion and is not writable.
// RL6 - Standby 1 powers the converter down; no conversion then.
// RL7 - Timer, external, comparator and PWM events may also start conversion.
// RL8 - Every conversion lasts exactly 60 converter clock cycles.
// RL9 - Software should discard first results after leaving standby.
// RL10 - Reference 0 uses supply; 1 uses external pin, disables input zero.
// RL11 - Address 9BH reads second mode in standby, else result high.
// RL12 - Result registers are read-only and hold the last completed value.
// RL13 - Start bit clears itself when the conversion completes.
// RL14 - Codes 0 to 14 pick external inputs, 15 the core supply.
// RL15 - Alignment 0 left-justifies the result, alignment 1 right-justifies.
// RL16 - Converter clock is system clock over 2, 4, 8 or 32.
module adcc_conversion_control #(
   parameter int CONV_CYCLES = adcc_pkg::CONV_TICKS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic [7:0] trigEvent,
   input wire logic compTrig,
   input wire logic pwmTrig,
   input wire logic compIn,
   output logic [3:0] channelSel,
   output logic coreSupplySel,
   output logic externalRefSel,
   output logic analogZeroDisable,
   output logic powerDown,
   output logic altClockSel,
   output logic convClk,
   output logic sampleHold,
   output logic [11:0] dacCode,
   output logic irq
);
   import adcc_pkg::*;

   localparam int RB = RESULT_BITS;
   localparam int SAMPLE_CYCLES = CONV_CYCLES - RB;
   localparam int CW = $clog2(CONV_CYCLES);
   localparam logic [CW-1:0] LAST_TICK = CW'(CONV_CYCLES - 1);
   localparam logic [CW-1:0] SAMPLE_LAST = CW'(SAMPLE_CYCLES - 1);
   localparam logic [RB-1:0] TOP_BIT = {1'b1, {(RB - 1){1'b0}}};

   // The sample phase needs at least one converter clock
   if (CONV_CYCLES < RB + 1 || CONV_CYCLES > 255) begin : g_bad_ticks
      $error("CONV_CYCLES must lie between 13 and 255");
   end

   // Register state
   logic converter_standby_q, converter_standby_d;
   logic reference_select_q, reference_select_d;
   logic done_q, done_d;
   logic [3:0] chan_q, chan_d;
   logic [7:0] mode2_q, mode2_d;
   logic [1:0] trigEn_q, trigEn_d;
   logic irqStat_q, irqStat_d;
   logic irqMask_q, irqMask_d;
   logic [RB-1:0] result_q, result_d;
   logic [7:0] rdData_q, rdData_d;
   logic irq_q, irq_d;
   logic coreSup_q, coreSup_d;
   logic sampleHold_q, sampleHold_d;
   logic convClk_q, convClk_d;

   // Sequencer state
   adcc_state_type state_q, state_d;
   logic [4:0] div_q, div_d;
   logic [CW-1:0] tickCnt_q, tickCnt_d;
   logic [RB-1:0] sar_q, sar_d;
   logic [RB-1:0] bitMask_q, bitMask_d;

   // Address decode
   wire selMode = regAddr == ADDR_MODE;
   wire selHigh = regAddr == ADDR_RES_HIGH;
   wire selLow = regAddr == ADDR_RES_LOW;
   wire selTrig = regAddr == ADDR_TRIG_EN;
   wire selStat = regAddr == ADDR_IRQ_STAT;
   wire selMask = regAddr == ADDR_IRQ_MASK;
   wire wrMode = regWr && selMode;
   wire wrMode2 = regWr && selHigh;
   wire wrTrig = regWr && selTrig;
   wire wrStat = regWr && selStat;
   wire wrMask = regWr && selMask;

   // Mode register fields after this cycle's write
   assign converter_standby_d = wrMode ? regWrData[MODE_CONVERTER_STANDBY] : converter_standby_q;
   assign reference_select_d = wrMode ? regWrData[MODE_REF] : reference_select_q;
   assign chan_d = wrMode ? regWrData[3:0] : chan_q; // RL2
   assign coreSup_d = chan_d == CHAN_CORE_SUPPLY; // RL14

   // Writes to 9BH always land in the second mode register
   assign mode2_d = wrMode2 ? regWrData : mode2_q; // RL11
   assign trigEn_d = wrTrig ? regWrData[1:0] : trigEn_q;
   assign irqMask_d = wrMask ? regWrData[IRQ_DONE] : irqMask_q;

   // Second mode register fields
   wire extTrigEn = mode2_q[MODE2_EXTRG];
   wire [2:0] trigSrc = mode2_q[MODE2_TSEL+2:MODE2_TSEL];
   wire alignRight = mode2_q[MODE2_ALIGN];
   wire [1:0] clkSelect = mode2_q[1:0];

   wire idle = state_q == ST_IDLE;

   // Start and stop requests
   wire swStart = wrMode && regWrData[MODE_START]; // RL3
   wire swStop = wrMode && !regWrData[MODE_START]; // RL3
   wire extHit = extTrigEn && trigEvent[trigSrc]; // RL7
   wire compHit = trigEn_q[TRIG_EN_COMP] && compTrig; // RL7
   wire pwmHit = trigEn_q[TRIG_EN_PWM] && pwmTrig; // RL7
   wire hwStart = extHit || compHit || pwmHit; // RL7

   // Nothing starts while standby is set or being set this cycle
   wire startConv = idle && !converter_standby_d && (swStart || hwStart); // RL6
   wire abortConv = !idle && (converter_standby_d || swStop); // RL6

   // Converter clock prescaler
   logic [4:0] divLast;
   always_comb begin
      unique case (clkSelect) // RL16
         CONVERTER_CLOCK_DIVIDE_DIV2: divLast = DIV2_LAST;
         CONVERTER_CLOCK_DIVIDE_DIV4: divLast = DIV4_LAST;
         CONVERTER_CLOCK_DIVIDE_DIV8: divLast = DIV8_LAST;
         default: divLast = DIV32_LAST;
      endcase
   end

   // Wraps in idle too, so the converter clock runs free at the chosen rate
   wire divWrap = div_q == divLast;
   wire tick = !idle && divWrap;

   // Prescaler restarts with each conversion so the first tick is a full period
   assign div_d = (startConv || converter_standby_q || divWrap) ? DIV_RESET : div_q + 5'h01;
   // Clock idles low in standby so the powered-down core sees no edges
   assign convClk_d = !converter_standby_d && div_d <= (divLast >> 1);

   // Tick counter spans the whole conversion
   wire sampleEnd = tick && tickCnt_q == SAMPLE_LAST; // RL8
   wire lastTick = tick && tickCnt_q == LAST_TICK; // RL8

   always_comb begin
      tickCnt_d = tickCnt_q;
      if (startConv) begin
         tickCnt_d = '0;
      end else if (tick) begin
         tickCnt_d = tickCnt_q + CW'(1);
      end
   end

   // Sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (startConv) begin
               state_d = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (abortConv) begin
               state_d = ST_IDLE;
            end else if (sampleEnd) begin
               state_d = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            if (abortConv || lastTick) begin
               state_d = ST_IDLE; // RL8
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   wire converting = state_q == ST_CONVERT;
   // An abort in the last tick wins, so no partial result is loaded
   wire complete = converting && lastTick && !abortConv; // RL4
   assign sampleHold_d = state_d == ST_SAMPLE;

   // Successive approximation: keep or drop the trial bit, then try the next one
   // Comparator is taken only on ticks; the core has one converter clock to settle
   wire [RB-1:0] kept = compIn ? sar_q : (sar_q & ~bitMask_q); // RL1
   wire [RB-1:0] trial = kept | (bitMask_q >> 1); // RL1

   always_comb begin
      sar_d = sar_q;
      bitMask_d = bitMask_q;
      if (state_q == ST_SAMPLE && sampleEnd) begin
         sar_d = TOP_BIT;
         bitMask_d = TOP_BIT;
      end else if (converting && tick) begin
         sar_d = trial;
         bitMask_d = bitMask_q >> 1;
      end
   end

   // Result holds until the next completed conversion
   assign result_d = complete ? kept : result_q; // RL12

   // Done flag: cleared at start, set on completion, never written
   always_comb begin
      done_d = done_q;
      if (complete) begin
         done_d = 1'b1; // RL4
      end else if (startConv) begin
         done_d = 1'b0; // RL5
      end
   end

   // Sticky status; a completion in the clearing cycle wins
   wire statClr = wrStat && regWrData[IRQ_DONE];
   assign irqStat_d = complete || (irqStat_q && !statClr); // RL4
   assign irq_d = irqStat_d && irqMask_d;

   // Result alignment
   wire [7:0] resHigh = alignRight ? {4'h0, result_q[11:8]} : result_q[11:4]; // RL15
   wire [7:0] resLow = alignRight ? result_q[7:0] : {result_q[3:0], 4'h0}; // RL15

   // Start bit reads back as busy, so it clears itself on completion
   wire [7:0] modeRead = {converter_standby_q, !idle, reference_select_q, done_q, chan_q}; // RL13

   // In standby 9BH shows the second mode register
   wire [7:0] highRead = converter_standby_q ? mode2_q : resHigh; // RL11

   // Idle cycles and unmapped addresses read as zero
   always_comb begin
      rdData_d = BYTE_ZERO;
      if (regRd) begin
         if (selMode) begin
            rdData_d = modeRead;
         end else if (selHigh) begin
            rdData_d = highRead;
         end else if (selLow) begin
            rdData_d = resLow;
         end else if (selTrig) begin
            rdData_d = {6'h00, trigEn_q};
         end else if (selStat) begin
            rdData_d = {7'h00, irqStat_q};
         end else if (selMask) begin
            rdData_d = {7'h00, irqMask_q};
         end
      end
   end

   // Mode register fields and the pins they drive
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         converter_standby_q <= MODE_RESET[MODE_CONVERTER_STANDBY];
         reference_select_q <= MODE_RESET[MODE_REF];
         done_q <= MODE_RESET[MODE_DONE];
         chan_q <= MODE_RESET[3:0];
         coreSup_q <= 1'b1;
      end else begin
         converter_standby_q <= converter_standby_d;
         reference_select_q <= reference_select_d;
         done_q <= done_d;
         chan_q <= chan_d;
         coreSup_q <= coreSup_d;
      end
   end

   // Second mode, trigger enables and interrupt mask
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mode2_q <= MODE2_RESET;
         trigEn_q <= 2'h0;
         irqMask_q <= 1'b0;
      end else begin
         mode2_q <= mode2_d;
         trigEn_q <= trigEn_d;
         irqMask_q <= irqMask_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irqStat_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         irqStat_q <= irqStat_d;
         irq_q <= irq_d;
      end
   end

   // Read data and the held result
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdData_q <= BYTE_ZERO;
         result_q <= RESULT_RESET;
      end else begin
         rdData_q <= rdData_d;
         result_q <= result_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         div_q <= DIV_RESET;
         tickCnt_q <= '0;
      end else begin
         state_q <= state_d;
         div_q <= div_d;
         tickCnt_q <= tickCnt_d;
      end
   end

   // Approximation word and the core control pins
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sar_q <= RESULT_RESET;
         bitMask_q <= RESULT_RESET;
         sampleHold_q <= 1'b0;
         convClk_q <= 1'b0;
      end else begin
         sar_q <= sar_d;
         bitMask_q <= bitMask_d;
         sampleHold_q <= sampleHold_d;
         convClk_q <= convClk_d;
      end
   end

   // Outputs, each a flip-flop
   assign regRdData = rdData_q;
   assign channelSel = chan_q;
   assign coreSupplySel = coreSup_q;
   assign externalRefSel = reference_select_q; // RL10
   assign analogZeroDisable = reference_select_q; // RL10
   assign powerDown = converter_standby_q; // RL6
   assign altClockSel = mode2_q[MODE2_ALTCLK];
   assign convClk = convClk_q;
   assign sampleHold = sampleHold_q;
   assign dacCode = sar_q; // RL1
   assign irq = irq_q;

endmodule

// file: tb/adcc_core_model.sv
// Behavioural analog multiplexer and comparator standing behind the converter control
module adcc_core_model (
   input wire logic clk,
   input wire logic [3:0] channelSel,
   input wire logic externalRefSel,
   input wire logic powerDown,
   input wire logic [11:0] dacCode,
   output logic compIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] inputLevel;
   logic idleToggle = 1'b0;
   // Each channel gets a distinct level so a wrong mux select shows in the result
   assign inputLevel = (externalRefSel && channelSel == 4'h0) ? 12'h000 :
      {channelSel, channelSel ^ 4'hA, 4'hC};
   // A powered-down comparator gives no stable answer
   always @(posedge clk) idleToggle <= ~idleToggle;
   assign compIn = powerDown ? idleToggle : (inputLevel >= dacCode);
endmodule

// file: tb/adcc_checker.sv
// Port-level assertions for the converter control block
module adcc_checker #(
   parameter int CONV_CYCLES = 60
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdData,
   input wire logic [3:0] channelSel,
   input wire logic coreSupplySel,
   input wire logic externalRefSel,
   input wire logic analogZeroDisable,
   input wire logic powerDown,
   input wire logic convClk,
   input wire logic sampleHold,
   input wire logic irq
);
   import adcc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   ref_zero_tie_a: assert property (externalRefSel == analogZeroDisable)
      else $error("reference select and input zero disable differ");
   supply_chan_a: assert property ($stable(channelSel) |->
      coreSupplySel == (channelSel == CHAN_CORE_SUPPLY)) else $error("core supply select wrong");
   clk_standby_a: assert property (powerDown [*3] |-> !convClk)
      else $error("converter clock runs in standby");
   sample_standby_a: assert property (powerDown [*3] |-> !sampleHold)
      else $error("sampling in standby");
   rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == BYTE_ZERO)
      else $error("read data outside read cycle");
   done_busy_a: assert property (regRd && regAddr == ADDR_MODE |=>
      !(regRdData[MODE_START] && regRdData[MODE_DONE])) else $error("done set while busy");
   converter_standby_read_a: assert property (regRd && regAddr == ADDR_MODE |=>
      regRdData[MODE_CONVERTER_STANDBY] == $past(powerDown)) else $error("standby readback wrong");
   chan_read_a: assert property (regRd && regAddr == ADDR_MODE |=>
      regRdData[3:0] == $past(channelSel)) else $error("channel readback wrong");
   ref_read_a: assert property (regRd && regAddr == ADDR_MODE |=>
      regRdData[MODE_REF] == $past(externalRefSel)) else $error("reference readback wrong");
   busy_standby_a: assert property (regRd && regAddr == ADDR_MODE && powerDown |=>
      !regRdData[MODE_START]) else $error("busy in standby");
   irq_mask_a: assert property (regWr && regAddr == ADDR_IRQ_MASK && !regWrData[IRQ_DONE]
      |-> ##2 !irq) else $error("interrupt survives mask");
endmodule
bind adcc_conversion_control adcc_checker #(.CONV_CYCLES(CONV_CYCLES)) u_checker (
   .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
   .regRd(regRd), .regRdData(regRdData), .channelSel(channelSel),
   .coreSupplySel(coreSupplySel), .externalRefSel(externalRefSel),
   .analogZeroDisable(analogZeroDisable), .powerDown(powerDown), .convClk(convClk),
   .sampleHold(sampleHold), .irq(irq));

// file: tb/adcc_conversion_control_tb.sv
// Self-checking bench for the converter control block
module adcc_conversion_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import adcc_pkg::*;
   // Short conversion keeps the run brief; divider stays at its reset value of four
   localparam int CONV = 13;
   logic clk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0, compTrig = 1'b0, pwmTrig = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, trigEvent = 8'h00, regRdData;
   logic compIn, coreSupplySel, externalRefSel, analogZeroDisable, powerDown, altClockSel;
   logic convClk, sampleHold, irq;
   logic [3:0] channelSel;
   logic [11:0] dacCode;
   int n_errors = 0, total_checks = 0, n;
   initial forever #2.5 clk = ~clk;
   adcc_conversion_control #(.CONV_CYCLES(CONV)) u_dut (.clk(clk), .reset_n(reset_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .trigEvent(trigEvent), .compTrig(compTrig), .pwmTrig(pwmTrig),
      .compIn(compIn), .channelSel(channelSel), .coreSupplySel(coreSupplySel),
      .externalRefSel(externalRefSel), .analogZeroDisable(analogZeroDisable),
      .powerDown(powerDown), .altClockSel(altClockSel), .convClk(convClk),
      .sampleHold(sampleHold), .dacCode(dacCode), .irq(irq));
   adcc_core_model u_core (.clk(clk), .channelSel(channelSel), .externalRefSel(externalRefSel),
      .powerDown(powerDown), .dacCode(dacCode), .compIn(compIn));
   task automatic test_done;
      if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdData, exp);
   endtask
   // Counts cycles from the starting edge until the interrupt is seen, bounded
   task automatic waitIrq;
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rdChk(ADDR_MODE, MODE_RESET);
      rdChk(ADDR_RES_HIGH, MODE2_RESET);
      rdChk(8'h50, BYTE_ZERO);
      wr(ADDR_MODE, 8'h03);
      wr(ADDR_IRQ_MASK, 8'h01);
      chk({4'h0, channelSel}, 8'h03);
      rdChk(ADDR_RES_HIGH, BYTE_ZERO);
      // First result after leaving standby is thrown away
      wr(ADDR_MODE, 8'h43);
      waitIrq();
      wr(ADDR_IRQ_STAT, 8'h01);
      wr(ADDR_MODE, 8'h43);
      waitIrq();
      chk(8'(n), 8'(CONV * 4));
      rdChk(ADDR_MODE, 8'h13);
      rdChk(ADDR_RES_HIGH, 8'h39);
      rdChk(ADDR_RES_LOW, 8'hC0);
      wr(ADDR_RES_HIGH, 8'h05);
      wr(ADDR_RES_LOW, 8'hFF);
      rdChk(ADDR_RES_HIGH, 8'h03);
      rdChk(ADDR_RES_LOW, 8'h9C);
      rdChk(ADDR_IRQ_STAT, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_IRQ_STAT, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h01);
      #1 chk({7'h0, irq}, 8'h00);
      wr(ADDR_MODE, 8'h43);
      rdChk(ADDR_MODE, 8'h43);
      chk({7'h0, sampleHold}, 8'h01);
      wr(ADDR_MODE, 8'h03);
      repeat (80) @(posedge clk);
      #1 chk({7'h0, irq}, 8'h00);
      rdChk(ADDR_MODE, 8'h03);
      wr(ADDR_MODE, 8'h0F);
      // Idle converter clock at divide-by-four is high two cycles in four
      n = 0;
      repeat (8) begin
         @(posedge clk);
         #1 n += int'(convClk);
      end
      chk(8'(n), 8'h04);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_RES_HIGH, i == 0 ? 8'hB5 : 8'h05);
         wr(ADDR_TRIG_EN, 8'(i));
         @(posedge clk);
         trigEvent[3] <= (i == 0);
         compTrig <= (i == 1);
         pwmTrig <= (i == 2);
         @(posedge clk);
         trigEvent <= 8'h00;
         compTrig <= 1'b0;
         pwmTrig <= 1'b0;
         waitIrq();
         chk(8'(n), 8'(CONV * 4));
         rdChk(ADDR_RES_HIGH, 8'h0F);
         rdChk(ADDR_RES_LOW, 8'h5C);
         wr(ADDR_IRQ_STAT, 8'h01);
      end
      wr(ADDR_MODE, 8'hE3);
      repeat (80) @(posedge clk);
      #1 chk({6'h0, powerDown, irq}, 8'h02);
      chk({6'h0, externalRefSel, analogZeroDisable}, 8'h03);
      rdChk(ADDR_RES_HIGH, 8'h05);
      wr(ADDR_RES_HIGH, 8'h0D);
      #1 chk({7'h0, altClockSel}, 8'h01);
      rdChk(ADDR_RES_HIGH, 8'h0D);
      test_done();
   end
   // Whole sequence needs under two thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      test_done();
   end
endmodule
